//--- speed_follower.sv
// Speed reference selection, pulse-following loop and follower output
`timescale 1ns/1ps
module speed_follower (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic dig_sel_pin,
	input wire logic mode_jumper,
	input wire logic ref_pulse_pin,
	input wire logic enc_a_pin,
	input wire logic enc_b_pin,
	input wire logic cur_limit_pin,
	input wire logic freq_oc_in,
	output logic freq_oc_out,
	output logic freq_oc_oe,
	output logic [15:0] torque_cmd,
	output logic torque_at_limit,
	output logic digital_mode
);
	// Synchronized pins
	logic [6:0] pins_s;
	logic [6:0] pins_p;
	logic dig_sel_s;
	logic jumper_s;
	logic ref_s;
	logic ref_rise;
	logic enc_a_s;
	logic enc_b_s;
	logic cur_lim_s;
	logic freq_pin_s;
	speed_follower_pkg::quad_step_t fb_step;

	// Bus side
	logic [7:0] addr_r;
	logic wr_r;
	logic take;
	logic [31:0] rd_mux;

	// Software registers
	logic [1:0] ctrl_r;
	logic [15:0] speed_set_r;
	logic [15:0] accel_r;
	logic [15:0] decel_r;
	logic [15:0] jog_r;
	logic [15:0] min_speed_r;
	logic [15:0] max_speed_r;

	// Analog path: ramp and oscillator
	localparam int VCO_W = speed_follower_pkg::VCO_ACC_W;
	logic [15:0] rate_r;
	logic [15:0] rate_nxt;
	logic [15:0] target;
	logic [15:0] trimmed;
	logic [7:0] tick_cnt_r;
	logic tick;
	logic [VCO_W:0] vco_acc_r;
	logic vco_pulse;

	// Following loop
	logic run;
	logic cmd_pulse;
	logic signed [17:0] err_r;
	logic signed [17:0] err_sum;
	logic signed [17:0] err_nxt;
	logic signed [17:0] err_lim;
	logic signed [17:0] torque_full;
	logic [31:0] fb_pos_r;

	// Follower output
	speed_follower_pkg::fo_state_t fo_state_r;
	speed_follower_pkg::fo_state_t fo_state_nxt;
	logic [7:0] fo_pend_r;
	logic [7:0] fo_pend_nxt;
	logic [15:0] fo_timer_r;
	logic fo_start;
	logic fo_done;
	logic fb_any;

	// Error beyond this already saturates torque; tested before the shift,
	// since a large backlog shifted inside 18 bits would wrap and flip sign
	localparam logic signed [17:0] TQ_ERR_MAX =
		speed_follower_pkg::TORQUE_MAX >>> speed_follower_pkg::KP_SHIFT;

	// Saturate a signed value to plus or minus a limit
	function automatic logic signed [17:0] sat(input logic signed [17:0] x,
		input logic signed [17:0] lim);
		if (x > lim)
			sat = lim;
		else if (x < -lim)
			sat = -lim;
		else
			sat = x;
	endfunction

	// Move a rate one step toward its target without overshoot
	function automatic logic [15:0] step_to(input logic [15:0] cur, input logic [15:0] tgt,
		input logic [15:0] up, input logic [15:0] dn);
		logic [16:0] s;
		s = 17'h00000;
		if (cur < tgt) begin
			s = {1'b0, cur} + {1'b0, up};
			step_to = (s > {1'b0, tgt}) ? tgt : s[15:0];
		end else if (cur > tgt) begin
			step_to = ((cur - tgt) < dn) ? tgt : cur - dn;
		end else begin
			step_to = cur;
		end
	endfunction

	// All pins come from outside the clock domain
	pin_sync #(.W(7)) u_pins (
		.clock(clock),
		.sys_rst(sys_rst),
		.d({freq_oc_in, cur_limit_pin, enc_b_pin, enc_a_pin, ref_pulse_pin, mode_jumper,
			dig_sel_pin}),
		.q(pins_s),
		.q_prev(pins_p)
	);

	assign dig_sel_s = pins_s[0];
	assign jumper_s = pins_s[1];
	assign ref_s = pins_s[2];
	assign enc_a_s = pins_s[3];
	assign enc_b_s = pins_s[4];
	assign cur_lim_s = pins_s[5];
	assign freq_pin_s = pins_s[6];
	assign ref_rise = ref_s & ~pins_p[2];

	// Encoder feedback counts
	quad_decoder u_quad (
		.clock(clock),
		.sys_rst(sys_rst),
		.enc_a(enc_a_s),
		.enc_b(enc_b_s),
		.step(fb_step)
	);

	// Mode selection: either the select pin or the jumper gives digital mode
	assign digital_mode = dig_sel_s | (jumper_s == speed_follower_pkg::JUMPER_DIGITAL);

	// AHB-Lite slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign take = hsel & hready & htrans[1];

	// Read mux; unmapped addresses read as zero
	always_comb begin
		rd_mux = 32'h00000000;
		case (haddr[7:0])
			speed_follower_pkg::REG_CTRL: rd_mux = {30'h00000000, ctrl_r};
			speed_follower_pkg::REG_SPEED_SET: rd_mux = {16'h0000, speed_set_r};
			speed_follower_pkg::REG_ACCEL: rd_mux = {16'h0000, accel_r};
			speed_follower_pkg::REG_DECEL: rd_mux = {16'h0000, decel_r};
			speed_follower_pkg::REG_JOG_SPEED: rd_mux = {16'h0000, jog_r};
			speed_follower_pkg::REG_MIN_SPEED: rd_mux = {16'h0000, min_speed_r};
			speed_follower_pkg::REG_MAX_SPEED: rd_mux = {16'h0000, max_speed_r};
			speed_follower_pkg::REG_STATUS: rd_mux = {26'h0000000, freq_pin_s, dig_sel_s,
				jumper_s, cur_lim_s, torque_at_limit, digital_mode};
			speed_follower_pkg::REG_FOLLOW_ERR: rd_mux = {{14{err_r[17]}}, err_r};
			speed_follower_pkg::REG_VCO_RATE: rd_mux = {16'h0000, rate_r};
			speed_follower_pkg::REG_FB_POS: rd_mux = fb_pos_r;
			default: rd_mux = 32'h00000000;
		endcase
		if (haddr[31:8] != 24'h000000)
			rd_mux = 32'h00000000;
	end

	// Address phase capture; read data registered for the data phase
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			addr_r <= 8'h00;
			wr_r <= 1'b0;
			hrdata <= 32'h00000000;
		end else begin
			wr_r <= take & hwrite & (haddr[31:8] == 24'h000000);
			addr_r <= haddr[7:0];
			if (take & ~hwrite)
				hrdata <= rd_mux;
		end
	end

	// Register writes in the data phase
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= speed_follower_pkg::CTRL_RST;
			speed_set_r <= speed_follower_pkg::SPEED_RST;
			accel_r <= speed_follower_pkg::ACCEL_RST;
			decel_r <= speed_follower_pkg::DECEL_RST;
			jog_r <= speed_follower_pkg::SPEED_RST;
			min_speed_r <= speed_follower_pkg::SPEED_RST;
			max_speed_r <= speed_follower_pkg::MAX_SPEED_RST;
		end else if (wr_r) begin
			case (addr_r)
				speed_follower_pkg::REG_CTRL: ctrl_r <= hwdata[1:0];
				speed_follower_pkg::REG_SPEED_SET: speed_set_r <= hwdata[15:0];
				speed_follower_pkg::REG_ACCEL: accel_r <= hwdata[15:0];
				speed_follower_pkg::REG_DECEL: decel_r <= hwdata[15:0];
				speed_follower_pkg::REG_JOG_SPEED: jog_r <= hwdata[15:0];
				speed_follower_pkg::REG_MIN_SPEED: min_speed_r <= hwdata[15:0];
				speed_follower_pkg::REG_MAX_SPEED: max_speed_r <= hwdata[15:0];
				default: ctrl_r <= ctrl_r;
			endcase
		end
	end

	assign run = ctrl_r[speed_follower_pkg::CTRL_RUN_BIT];

	// Speed target: jog overrides run speed, trims bound the setpoint
	assign trimmed = (speed_set_r < min_speed_r) ? min_speed_r :
		(speed_set_r > max_speed_r) ? max_speed_r : speed_set_r;
	assign target = !run ? 16'h0000 :
		ctrl_r[speed_follower_pkg::CTRL_JOG_BIT] ? jog_r : trimmed;

	// Ramp tick divider
	assign tick = (tick_cnt_r == 8'(speed_follower_pkg::RAMP_TICK_CYC - 1));

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			tick_cnt_r <= 8'h00;
		else
			tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
	end

	// Accel/decel stage; held at zero in digital mode so knobs do nothing
	assign rate_nxt = digital_mode ? 16'h0000 :
		tick ? step_to(rate_r, target, accel_r, decel_r) : rate_r;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			rate_r <= 16'h0000;
		else
			rate_r <= rate_nxt;
	end

	// Oscillator: phase accumulator whose carry is one command pulse
	assign vco_pulse = vco_acc_r[VCO_W];

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			vco_acc_r <= '0;
		else
			vco_acc_r <= {1'b0, vco_acc_r[VCO_W-1:0]} + {{(VCO_W-15){1'b0}}, rate_r};
	end

	// Command source: oscillator is cut off while external pulses govern
	assign cmd_pulse = run & (digital_mode ? ref_rise : vco_pulse);

	// Following error: plus one per command, minus one per forward count
	assign err_sum = err_r + (cmd_pulse ? 18'sh00001 : 18'sh00000) +
		(fb_step.dn ? 18'sh00001 : 18'sh00000) -
		(fb_step.up ? 18'sh00001 : 18'sh00000);
	// In current limit the error is capped, so excess pulses are lost
	assign err_lim = cur_lim_s ? speed_follower_pkg::ERR_LIMIT_CL :
		speed_follower_pkg::ERR_LIMIT_MAX;
	assign err_nxt = run ? sat(err_sum, err_lim) : 18'sh00000;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			err_r <= 18'sh00000;
		else
			err_r <= err_nxt;
	end

	// Torque demand from error; a backlog of pulses at start pins it at limit
	assign torque_full = (err_r > TQ_ERR_MAX) ? speed_follower_pkg::TORQUE_MAX :
		(err_r < -TQ_ERR_MAX) ? -speed_follower_pkg::TORQUE_MAX :
		(err_r <<< speed_follower_pkg::KP_SHIFT);

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			torque_cmd <= 16'h0000;
			torque_at_limit <= 1'b0;
		end else begin
			torque_cmd <= torque_full[15:0];
			torque_at_limit <= (torque_full == speed_follower_pkg::TORQUE_MAX) ||
				(torque_full == -speed_follower_pkg::TORQUE_MAX);
		end
	end

	// Motor position in feedback counts, 120 per turn
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			fb_pos_r <= 32'h00000000;
		else if (fb_step.up)
			fb_pos_r <= fb_pos_r + 32'h00000001;
		else if (fb_step.dn)
			fb_pos_r <= fb_pos_r - 32'h00000001;
	end

	// Follower output: one pulse per real count, so it follows limit and stops
	assign fb_any = fb_step.up | fb_step.dn;
	assign fo_done = (fo_timer_r == 16'(speed_follower_pkg::FO_HALF_CYC - 1));
	assign fo_start = (fo_state_r == speed_follower_pkg::FO_IDLE || (fo_state_r ==
		speed_follower_pkg::FO_LOW && fo_done)) && (fo_pend_r != 8'h00);
	// A count arriving as a pulse starts is kept: add and remove both apply
	assign fo_pend_nxt = fo_pend_r + ((fb_any && fo_pend_r != 8'hFF) ? 8'h01 : 8'h00) -
		(fo_start ? 8'h01 : 8'h00);

	always_comb begin
		fo_state_nxt = fo_state_r;
		case (fo_state_r)
			speed_follower_pkg::FO_IDLE:
				if (fo_start)
					fo_state_nxt = speed_follower_pkg::FO_HIGH;
			speed_follower_pkg::FO_HIGH:
				if (fo_done)
					fo_state_nxt = speed_follower_pkg::FO_LOW;
			speed_follower_pkg::FO_LOW:
				if (fo_start)
					fo_state_nxt = speed_follower_pkg::FO_HIGH;
				else if (fo_done)
					fo_state_nxt = speed_follower_pkg::FO_IDLE;
			default: fo_state_nxt = speed_follower_pkg::FO_IDLE;
		endcase
	end

	// Each count gives a high and a low half of 5 us: 100 kHz ceiling
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fo_state_r <= speed_follower_pkg::FO_IDLE;
			fo_pend_r <= 8'h00;
			fo_timer_r <= 16'h0000;
		end else begin
			fo_state_r <= fo_state_nxt;
			fo_pend_r <= fo_pend_nxt;
			fo_timer_r <= (fo_state_nxt != fo_state_r || fo_done) ? 16'h0000 :
				fo_timer_r + 16'h0001;
		end
	end

	// Open collector: transistor on during the high half, pulling the pin low
	assign freq_oc_out = 1'b0;
	assign freq_oc_oe = (fo_state_r == speed_follower_pkg::FO_HIGH);

endmodule // speed_follower

//--- speed_follower_pkg.sv
// Shared constants, types and register map of the pulse-train speed follower
// Functional notes
// - Digital-mode select input enters digital mode
// - Jumper in digital position forces digital mode
// - Digital mode swaps oscillator for external pulses
// - Analog mode: ramp stage drives internal oscillator
// - Speed adjustments ignored in digital mode
// - One feedback count per reference pulse
// - 30-line encoder decodes to 120 counts
// - Open-collector output switches at twice RPM
// - Follower output tracks actual motor motion
// - Start with pulses present accelerates in limit
package speed_follower_pkg;

	// Clock and timing
	localparam int CLK_MHZ = 200;
	localparam int RAMP_TICK_NS = 1000;
	localparam int RAMP_TICK_CYC = (RAMP_TICK_NS * CLK_MHZ) / 1000;
	localparam int FO_HALF_NS = 5000;
	localparam int FO_HALF_CYC = (FO_HALF_NS * CLK_MHZ) / 1000;

	// Encoder geometry
	localparam int ENC_LINES = 30;
	localparam int ENC_COUNTS = 4 * ENC_LINES;

	// Level read on the jumper pin when it sits in the digital position
	localparam logic JUMPER_DIGITAL = 1'b1;

	// Loop constants
	localparam logic signed [17:0] ERR_LIMIT_CL = 18'sh003FF;
	localparam logic signed [17:0] ERR_LIMIT_MAX = 18'sh07FFF;
	localparam logic signed [17:0] TORQUE_MAX = 18'sh07FFF;
	localparam int KP_SHIFT = 6;
	localparam int VCO_ACC_W = 24;

	// Register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SPEED_SET = 8'h04;
	localparam logic [7:0] REG_ACCEL = 8'h08;
	localparam logic [7:0] REG_DECEL = 8'h0C;
	localparam logic [7:0] REG_JOG_SPEED = 8'h10;
	localparam logic [7:0] REG_MIN_SPEED = 8'h14;
	localparam logic [7:0] REG_MAX_SPEED = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	localparam logic [7:0] REG_FOLLOW_ERR = 8'h20;
	localparam logic [7:0] REG_VCO_RATE = 8'h24;
	localparam logic [7:0] REG_FB_POS = 8'h28;

	// Control fields and reset values
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_JOG_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [15:0] SPEED_RST = 16'h0000;
	localparam logic [15:0] ACCEL_RST = 16'h0001;
	localparam logic [15:0] DECEL_RST = 16'h0001;
	localparam logic [15:0] MAX_SPEED_RST = 16'hFFFF;

	// Status fields
	localparam int ST_DIGITAL = 0;
	localparam int ST_AT_LIMIT = 1;
	localparam int ST_CUR_LIMIT = 2;
	localparam int ST_JUMPER = 3;
	localparam int ST_DIG_SEL = 4;
	localparam int ST_FREQ_PIN = 5;

	// One decoded encoder step
	typedef struct packed {
		logic up;
		logic dn;
	} quad_step_t;

	// Frequency output sequencer
	typedef enum logic [1:0] {FO_IDLE, FO_HIGH, FO_LOW} fo_state_t;

endpackage

//--- pin_sync.sv
// Two-flop synchronizer with a third stage for edge detection
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] q_prev
);
	logic [W-1:0] meta_r;

	// Stage one is read only by stage two; edges compare stages two and three
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= '0;
			q <= '0;
			q_prev <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
			q_prev <= q;
		end
	end
endmodule // pin_sync

//--- quad_decoder.sv
// Full quadrature decoder: every edge of either channel is one count
`timescale 1ns/1ps
module quad_decoder (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic enc_a,
	input wire logic enc_b,
	output speed_follower_pkg::quad_step_t step
);
	logic [1:0] ab_r;
	logic [1:0] ab_now;
	logic fwd;
	logic rev;

	// Gray order 00-01-11-10 is forward; a double jump is noise and dropped
	function automatic logic is_fwd(input logic [1:0] p, input logic [1:0] n);
		is_fwd = (p == 2'h0 && n == 2'h1) || (p == 2'h1 && n == 2'h3) ||
			(p == 2'h3 && n == 2'h2) || (p == 2'h2 && n == 2'h0);
	endfunction

	assign ab_now = {enc_a, enc_b};
	assign fwd = is_fwd(ab_r, ab_now);
	assign rev = is_fwd(ab_now, ab_r);

	// Four counts per line give 120 per turn on a 30-line encoder
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ab_r <= 2'h0;
			step <= '0;
		end else begin
			ab_r <= ab_now;
			step.up <= fwd;
			step.dn <= rev;
		end
	end
endmodule // quad_decoder

//--- speed_follower_properties.sv
// Port-level properties of the pulse-train speed follower
`timescale 1ns/1ps
module speed_follower_properties (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic dig_sel_pin,
	input wire logic mode_jumper,
	input wire logic freq_oc_out,
	input wire logic freq_oc_oe,
	input wire logic [15:0] torque_cmd,
	input wire logic torque_at_limit,
	input wire logic digital_mode
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic [10:0] hi_r;
	logic [10:0] lo_r;
	logic [1:0] age_r;
	wire rd = hsel && hready && htrans[1] && !hwrite;
	wire want_dig = dig_sel_pin || (mode_jumper == speed_follower_pkg::JUMPER_DIGITAL);
	// Run lengths of the transistor; low count starts full so the first pulse passes
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			hi_r <= 11'h000;
			lo_r <= 11'h3E8;
			age_r <= 2'h0;
		end else begin
			hi_r <= freq_oc_oe ? hi_r + 11'h001 : 11'h000;
			lo_r <= freq_oc_oe ? 11'h000 : ((lo_r == 11'h3E8) ? lo_r : lo_r + 11'h001);
			age_r <= (age_r == 2'h3) ? age_r : age_r + 2'h1;
		end
	end
	property p_bus_okay;
		hreadyout && !hresp;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus answer not zero-wait OKAY");
	property p_oc_low;
		freq_oc_out == 1'b0;
	endproperty
	a_oc_low: assert property (p_oc_low) else $error("collector driven high");
	// Synchronizers clear in reset, so the relation holds only once they refilled
	property p_dig_mode;
		age_r == 2'h3 |-> digital_mode == $past(want_dig, 2);
	endproperty
	a_dig_mode: assert property (p_dig_mode) else $error("digital mode wrong");
	property p_oc_high_len;
		$fell(freq_oc_oe) |-> hi_r == 11'h3E8;
	endproperty
	a_oc_high_len: assert property (p_oc_high_len) else $error("on time not 1000");
	property p_oc_low_len;
		$rose(freq_oc_oe) |-> lo_r == 11'h3E8;
	endproperty
	a_oc_low_len: assert property (p_oc_low_len) else $error("off time short");
	property p_at_limit;
		torque_at_limit == (torque_cmd == 16'h7FFF || torque_cmd == 16'h8001);
	endproperty
	a_at_limit: assert property (p_at_limit) else $error("limit flag wrong");
	property p_rd_unmapped;
		rd && haddr > 32'h00000028 |=> hrdata == 32'h00000000;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
	property p_rd_ctrl;
		rd && haddr == 32'h00000000 |=> hrdata[31:2] == 30'h00000000;
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("control upper bits set");
	property p_rd_status;
		rd && haddr == 32'h0000001C |=> hrdata[1:0] == {$past(torque_at_limit), $past(digital_mode)};
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("status bits wrong");
endmodule // speed_follower_properties

bind speed_follower speed_follower_properties u_props (.clock(clock), .sys_rst(sys_rst),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dig_sel_pin(dig_sel_pin),
	.mode_jumper(mode_jumper), .freq_oc_out(freq_oc_out), .freq_oc_oe(freq_oc_oe),
	.torque_cmd(torque_cmd), .torque_at_limit(torque_at_limit), .digital_mode(digital_mode));

//--- ref_source.sv
// Reference pulse source standing at the far side of the pulse input
`timescale 1ns/1ps
module ref_source (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic go,
	input wire logic [7:0] count,
	output logic pulse,
	output logic busy
);
	logic [7:0] left_r;
	logic [12:0] tmr_r;
	logic first_r;
	// 2000 clocks per half is the 50 kHz ceiling; the first pulse is slower as a ramp
	wire [12:0] half_len = first_r ? 13'h0FA0 : 13'h07D0;
	// Square wave keeps duty at half; the pin rests low after the train
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			busy <= 1'b0;
			pulse <= 1'b0;
			left_r <= 8'h00;
			tmr_r <= 13'h0001;
			first_r <= 1'b1;
		end else if (!busy) begin
			busy <= go && count != 8'h00;
			left_r <= count;
			tmr_r <= 13'h0001;
			first_r <= 1'b1;
			pulse <= 1'b0;
		end else if (tmr_r != half_len) begin
			tmr_r <= tmr_r + 13'h0001;
		end else begin
			tmr_r <= 13'h0001;
			pulse <= !pulse;
			if (pulse) begin
				first_r <= 1'b0;
				left_r <= left_r - 8'h01;
				busy <= left_r != 8'h01;
			end
		end
	end
endmodule // ref_source

//--- tb.sv
// Self-checking bench for the pulse-train speed follower
`timescale 1ns/1ps
module tb;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic hreadyout, hresp, oc_out, oc_oe, at_lim, dig_mode, ref_pulse, busy;
	logic [31:0] hrdata;
	logic [31:0] rdata;
	logic [15:0] torque;
	logic dig_sel = 1'b0, jumper = 1'b0, enc_a = 1'b0, enc_b = 1'b0, cur_lim = 1'b0;
	logic go = 1'b0, oe_q = 1'b0;
	logic [7:0] npulse = 8'h00;
	logic [1:0] ph = 2'h0;
	int errors = 0, checks = 0, rises = 0;
	wire freq_pin = ~oc_oe; // Pull-up resistor on the collector
	always #2.5 clock = ~clock;
	speed_follower u_dut (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dig_sel_pin(dig_sel),
		.mode_jumper(jumper), .ref_pulse_pin(ref_pulse), .enc_a_pin(enc_a), .enc_b_pin(enc_b),
		.cur_limit_pin(cur_lim), .freq_oc_in(freq_pin), .freq_oc_out(oc_out), .freq_oc_oe(oc_oe),
		.torque_cmd(torque), .torque_at_limit(at_lim), .digital_mode(dig_mode));
	ref_source u_src (.clock(clock), .sys_rst(sys_rst), .go(go), .count(npulse),
		.pulse(ref_pulse), .busy(busy));
	// Count switch-ons of the output transistor
	always @(posedge clock) begin
		oe_q <= oc_oe;
		if (oc_oe === 1'b1 && oe_q === 1'b0) rises++;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One single transfer; the answer is awaited, never assumed
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		rdata = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(rdata, exp);
	endtask
	task automatic pulses(input logic [7:0] n);
		@(posedge clock);
		npulse <= n;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		@(posedge clock);
		while (busy === 1'b1) @(posedge clock);
		repeat (10) @(posedge clock);
	endtask
	// Gray steps {a,b} 00,01,11,10 run forward
	task automatic enc(input int n, input logic fwd);
		repeat (n) begin
			ph = fwd ? ph + 2'h1 : ph - 2'h1;
			@(posedge clock);
			{enc_a, enc_b} <= {ph[1], ph[1] ^ ph[0]};
			repeat (4) @(posedge clock);
		end
		repeat (10) @(posedge clock);
	endtask
	task automatic t_reset;
		chk({31'h0, dig_mode}, 32'h00000000);
		chk({30'h0, hresp, oc_out}, 32'h00000000);
		rchk(speed_follower_pkg::REG_CTRL, {30'h0, speed_follower_pkg::CTRL_RST});
		rchk(speed_follower_pkg::REG_SPEED_SET, {16'h0, speed_follower_pkg::SPEED_RST});
		rchk(speed_follower_pkg::REG_ACCEL, {16'h0, speed_follower_pkg::ACCEL_RST});
		rchk(speed_follower_pkg::REG_DECEL, {16'h0, speed_follower_pkg::DECEL_RST});
		rchk(speed_follower_pkg::REG_MAX_SPEED, {16'h0, speed_follower_pkg::MAX_SPEED_RST});
		bus(1'b1, 8'h3C, 32'hFFFFFFFF);
		rchk(8'h3C, 32'h00000000);
	endtask
	// All four dig_sel/jumper settings, cur_lim tied to jumper; idle transistor leaves the pin pulled high
	task automatic t_mode;
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			{dig_sel, jumper, cur_lim} <= {i[1], i[0], i[0]};
			repeat (4) @(posedge clock);
			bus(1'b0, speed_follower_pkg::REG_STATUS, 32'h00000000);
			chk(rdata & 32'h3F, {26'h0, 1'b1, i[1], i[0], i[0], 1'b0, i[1] | i[0]});
		end
		@(posedge clock);
		{dig_sel, jumper, cur_lim} <= 3'h0;
	endtask
	task automatic t_analog;
		bus(1'b1, speed_follower_pkg::REG_SPEED_SET, 32'h00000008);
		bus(1'b1, speed_follower_pkg::REG_MAX_SPEED, 32'h00000005);
		bus(1'b1, speed_follower_pkg::REG_CTRL, 32'h00000001);
		repeat (2000) @(posedge clock);
		rchk(speed_follower_pkg::REG_VCO_RATE, 32'h00000005);
		bus(1'b1, speed_follower_pkg::REG_JOG_SPEED, 32'h00000002);
		bus(1'b1, speed_follower_pkg::REG_CTRL, 32'h00000003);
		repeat (2000) @(posedge clock);
		rchk(speed_follower_pkg::REG_VCO_RATE, 32'h00000002);
		@(posedge clock);
		jumper <= 1'b1;
		repeat (2000) @(posedge clock);
		rchk(speed_follower_pkg::REG_VCO_RATE, 32'h00000000);
		bus(1'b1, speed_follower_pkg::REG_MAX_SPEED, 32'h0000FFFF);
		bus(1'b1, speed_follower_pkg::REG_CTRL, 32'h00000001);
		repeat (1000) @(posedge clock);
		rchk(speed_follower_pkg::REG_VCO_RATE, 32'h00000000);
	endtask
	// Output pulses follow shaft motion, not the reference
	task automatic t_follow;
		pulses(8'h05);
		rchk(speed_follower_pkg::REG_FOLLOW_ERR, 32'h00000005);
		chk({16'h0, torque}, 32'h00000005 << speed_follower_pkg::KP_SHIFT);
		chk({31'h0, at_lim}, 32'h00000000);
		enc(5, 1'b1);
		rchk(speed_follower_pkg::REG_FOLLOW_ERR, 32'h00000000);
		rchk(speed_follower_pkg::REG_FB_POS, 32'h00000005);
		enc(2, 1'b0);
		rchk(speed_follower_pkg::REG_FOLLOW_ERR, 32'h00000002);
		rchk(speed_follower_pkg::REG_FB_POS, 32'h00000003);
		chk({16'h0, torque}, 32'h00000002 << speed_follower_pkg::KP_SHIFT);
		repeat (14500) @(posedge clock);
		chk(rises, 32'h00000007);
	endtask
	task automatic t_stop;
		bus(1'b1, speed_follower_pkg::REG_CTRL, 32'h00000000);
		rchk(speed_follower_pkg::REG_FOLLOW_ERR, 32'h00000000);
		@(posedge clock);
		jumper <= 1'b0;
		bus(1'b1, speed_follower_pkg::REG_CTRL, 32'h00000001);
		pulses(8'h01);
		rchk(speed_follower_pkg::REG_FOLLOW_ERR, 32'h00000000);
		// Rate 0x4000 on a 24-bit accumulator carries every 1024 clocks; after
		// up to 200 clocks of ramp latency, 2300 clocks hold two or three carries
		bus(1'b1, speed_follower_pkg::REG_ACCEL, 32'h0000FFFF);
		bus(1'b1, speed_follower_pkg::REG_SPEED_SET, 32'h00004000);
		repeat (2300) @(posedge clock);
		bus(1'b0, speed_follower_pkg::REG_FOLLOW_ERR, 32'h00000000);
		chk({31'h0, rdata >= 32'h00000002 && rdata <= 32'h00000003}, 32'h00000001);
	endtask
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence after a 16-cycle reset
	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset;
		t_mode;
		t_analog;
		t_follow;
		t_stop;
		test_done;
	end
	// Watchdog well past the roughly 56k cycles the tests need
	initial begin
		repeat (90000) @(posedge clock);
		errors++;
		test_done;
	end
endmodule // tb
